// ### src/phy_lat_map.svh
// Constants of the MII-to-media latency path: timing budgets and line codes
`ifndef PHY_LAT_MAP_SVH
`define PHY_LAT_MAP_SVH

// System clock period and bit times, ns
`define CLK_NS 40
`define BIT_NS_100 10
`define BIT_NS_10 100

// Latency budgets in tenths of a bit time (6.0, 17.5, 21, 21.5, 6.8)
`define TX100_SSD_MAX_BT10 60
`define TX100_ESD_MAX_BT10 60
`define RX100_CRS_ON_MAX_BT10 175
`define RX100_DATA_MAX_BT10 210
`define RX100_CRS_OFF_MAX_BT10 215
`define TX10_START_MAX_BT10 68

// Longest times round down to whole system cycles
`define TX100_SSD_MAX_CYC ((`TX100_SSD_MAX_BT10 * `BIT_NS_100) / (10 * `CLK_NS))
`define TX100_ESD_MAX_CYC ((`TX100_ESD_MAX_BT10 * `BIT_NS_100) / (10 * `CLK_NS))
`define RX100_CRS_ON_MAX_CYC ((`RX100_CRS_ON_MAX_BT10 * `BIT_NS_100) / (10 * `CLK_NS))
`define RX100_DATA_MAX_CYC ((`RX100_DATA_MAX_BT10 * `BIT_NS_100) / (10 * `CLK_NS))
`define RX100_CRS_OFF_MAX_CYC ((`RX100_CRS_OFF_MAX_BT10 * `BIT_NS_100) / (10 * `CLK_NS))
`define TX10_START_MAX_CYC ((`TX10_START_MAX_BT10 * `BIT_NS_10) / (10 * `CLK_NS))

// End-of-packet high time, least, rounds up
`define TX10_EOP_MIN_NS 250
`define TX10_EOP_CYC ((`TX10_EOP_MIN_NS + `CLK_NS - 1) / `CLK_NS)

// Line code groups
`define CODE_J 5'h18
`define CODE_K 5'h11
`define CODE_T 5'h0d
`define CODE_R 5'h07
`define CODE_IDLE 5'h1f
`define LINE10_IDLE 5'h00
`define LINE10_EOP 5'h1f
`define PREAMBLE_NIB 4'h5

`endif

// ### src/phy_lat_pkg.sv
// Types and code-group functions of the MII latency path
package phy_lat_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_SSD = 5'h02,
        TX_DATA = 5'h04,
        TX_ESD = 5'h08,
        TX_EOP10 = 5'h10
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h1,
        RX_DATA = 2'h2
    } rx_state_t;

    // 4B5B encode of one nibble
    function automatic logic [4:0] enc_nibble(input logic [3:0] nib);
        logic [4:0] c;
        c = 5'h1e;
        case (nib)
            4'h0: c = 5'h1e;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0a;
            4'h5: c = 5'h0b;
            4'h6: c = 5'h0e;
            4'h7: c = 5'h0f;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'ha: c = 5'h16;
            4'hb: c = 5'h17;
            4'hc: c = 5'h1a;
            4'hd: c = 5'h1b;
            4'he: c = 5'h1c;
            default: c = 5'h1d;
        endcase
        return c;
    endfunction

    // 4B5B decode: {error, nibble}
    function automatic logic [4:0] dec_code(input logic [4:0] code);
        logic [4:0] r;
        r = 5'h10;
        for (int i = 0; i < 16; i++) begin
            if (enc_nibble(4'(i)) == code) begin
                r = {1'b0, 4'(i)};
            end
        end
        return r;
    endfunction

    typedef struct packed {
        logic [1:0] tx_clk;
        logic [1:0] tx_en;
        logic [7:0] txd;
        logic [9:0] rx_code;
        logic [1:0] speed_100;
    } sync_state_t;

    typedef struct packed {
        tx_state_t tx_st;
        rx_state_t rx_st;
        logic clk_d;
        logic [3:0] eop_cnt;
        logic [4:0] line;
        logic drive;
        logic crs;
        logic rx_dv;
        logic rx_er;
        logic [3:0] rxd;
        logic rx_clk;
    } core_state_t;
endpackage

// ### src/link_sync_if.sv
// Synchronised link signals passed from the pin stage to the core
`timescale 1ns/1ps
interface link_sync_if;
    logic tx_clk;
    logic tx_en;
    logic [3:0] txd;
    logic [4:0] rx_code;
    logic speed_100;
    modport pin_side (output tx_clk, tx_en, txd, rx_code, speed_100);
    modport core_side (input tx_clk, tx_en, txd, rx_code, speed_100);
endinterface

// ### src/link_pin_sync.sv
// Two-flop synchronisers for every pin that enters from outside the system clock
`timescale 1ns/1ps
module link_pin_sync (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic tx_clk_in,
    input wire logic tx_en_in,
    input wire logic [3:0] txd_in,
    input wire logic [4:0] rx_code_in,
    input wire logic speed_100_in,
    link_sync_if.pin_side sync_out
);
    phy_lat_pkg::sync_state_t st_r;
    phy_lat_pkg::sync_state_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_clk = {st_r.tx_clk[0], tx_clk_in};
        st_nxt.tx_en = {st_r.tx_en[0], tx_en_in};
        st_nxt.txd = {st_r.txd[3:0], txd_in};
        st_nxt.rx_code = {st_r.rx_code[4:0], rx_code_in};
        st_nxt.speed_100 = {st_r.speed_100[0], speed_100_in};
        if (reset_in) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        st_r <= st_nxt;
    end

    // Second stage only leaves the module
    assign sync_out.tx_clk = st_r.tx_clk[1];
    assign sync_out.tx_en = st_r.tx_en[1];
    assign sync_out.txd = st_r.txd[7:4];
    assign sync_out.rx_code = st_r.rx_code[9:5];
    assign sync_out.speed_100 = st_r.speed_100[1];
endmodule

// ### src/phy_mii_path_latency.sv
// MII-to-media transmit and receive framing path with bounded latency
`timescale 1ns/1ps
`include "phy_lat_map.svh"
module phy_mii_path_latency (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic speed_100_in,
    input wire logic mii_tx_clk_in,
    input wire logic mii_tx_en_in,
    input wire logic [3:0] mii_txd_in,
    input wire logic [4:0] media_rx_pair_in,
    output logic [4:0] media_tx_pair_out,
    output logic media_tx_drive_out,
    output logic mii_crs_out,
    output logic mii_rx_dv_out,
    output logic mii_rx_er_out,
    output logic [3:0] mii_rxd_out,
    output logic mii_rx_clk_out
);
    // Latency is counted from the edge seen after the two-flop synchroniser.
    // A 40 ns system clock adds one or two cycles before that edge, which
    // no logic here can win back, so the pin-to-line time exceeds the
    // 6 bit time transmit budgets at 100M. The core itself answers one cycle after
    // the detected edge, the least that a registered output allows.
    // Link clock, enable, data, line and speed all pass the synchroniser.
    link_sync_if sync_if ();

    link_pin_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .tx_clk_in(mii_tx_clk_in),
        .tx_en_in(mii_tx_en_in),
        .txd_in(mii_txd_in),
        .rx_code_in(media_rx_pair_in),
        .speed_100_in(speed_100_in),
        .sync_out(sync_if.pin_side)
    );

    // Whole core state in one register
    phy_lat_pkg::core_state_t st_r;
    phy_lat_pkg::core_state_t st_nxt;
    logic rise;
    logic fall;
    logic nib_edge;
    logic fast;
    logic [4:0] code;
    logic [4:0] dec;

    // Edges of the synchronised link clock; clk_d starts low after reset,
    // so a clock held low through reset gives no false edge
    assign rise = sync_if.tx_clk & ~st_r.clk_d;
    assign fall = ~sync_if.tx_clk & st_r.clk_d;
    assign fast = sync_if.speed_100;
    // 10M samples on the falling edge, 100M on the rising one
    assign nib_edge = fast ? rise : fall;
    assign code = sync_if.rx_code;
    assign dec = phy_lat_pkg::dec_code(code);

    // Frame-ending symbols at 100M: T, or idle if the T was lost
    function automatic logic end_fast(input logic [4:0] c);
        logic r;
        r = 1'b0;
        if (c == `CODE_T || c == `CODE_IDLE) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // Frame-ending symbols at 10M: released line or end-of-packet high
    function automatic logic end_slow(input logic [4:0] c);
        logic r;
        r = 1'b0;
        if (c == `LINE10_IDLE || c == `LINE10_EOP) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // Transmit and receive state machines; one nibble per link edge
    always_comb begin
        st_nxt = st_r;
        st_nxt.clk_d = sync_if.tx_clk;
        st_nxt.rx_clk = st_r.clk_d;
        case (st_r.tx_st)
            phy_lat_pkg::TX_IDLE: begin
                // 100M idles are driven continuously, 10M line is released
                st_nxt.drive = fast;
                if (nib_edge) begin
                    st_nxt.line = fast ? `CODE_IDLE : `LINE10_IDLE;
                    if (sync_if.tx_en && fast) begin
                        st_nxt.line = `CODE_J;
                        st_nxt.tx_st = phy_lat_pkg::TX_SSD;
                    end else if (sync_if.tx_en) begin
                        // Next cycle, far inside the 6.8 bit time budget
                        st_nxt.line = {1'b0, sync_if.txd};
                        st_nxt.drive = 1'b1;
                        st_nxt.tx_st = phy_lat_pkg::TX_DATA;
                    end
                end
            end
            phy_lat_pkg::TX_SSD: begin
                // K completes the start delimiter in place of preamble
                if (nib_edge) begin
                    st_nxt.line = `CODE_K;
                    st_nxt.tx_st = phy_lat_pkg::TX_DATA;
                end
            end
            phy_lat_pkg::TX_DATA: begin
                // Enable low at an edge closes the frame; the ending depends on speed
                if (nib_edge && sync_if.tx_en) begin
                    st_nxt.line = fast ? phy_lat_pkg::enc_nibble(sync_if.txd)
                                       : {1'b0, sync_if.txd};
                end else if (nib_edge && fast) begin
                    st_nxt.line = `CODE_T;
                    st_nxt.tx_st = phy_lat_pkg::TX_ESD;
                end else if (nib_edge) begin
                    // Count covers the whole high time, whatever the last bit
                    st_nxt.line = `LINE10_EOP;
                    st_nxt.eop_cnt = 4'(`TX10_EOP_CYC - 1);
                    st_nxt.tx_st = phy_lat_pkg::TX_EOP10;
                end
            end
            phy_lat_pkg::TX_ESD: begin
                // R follows T to close the end delimiter
                if (nib_edge) begin
                    st_nxt.line = `CODE_R;
                    st_nxt.tx_st = phy_lat_pkg::TX_IDLE;
                end
            end
            phy_lat_pkg::TX_EOP10: begin
                // Held on system cycles, not link edges, so a stopped clock cannot stretch it
                if (st_r.eop_cnt == 4'h0) begin
                    st_nxt.line = `LINE10_IDLE;
                    st_nxt.drive = 1'b0;
                    st_nxt.tx_st = phy_lat_pkg::TX_IDLE;
                end else begin
                    st_nxt.eop_cnt = st_r.eop_cnt - 4'h1;
                end
            end
            default: begin
                st_nxt.tx_st = phy_lat_pkg::TX_IDLE;
            end
        endcase
        // Receive framing, sampled on the same link edge as transmit
        case (st_r.rx_st)
            phy_lat_pkg::RX_IDLE: begin
                if (nib_edge && fast && code == `CODE_J) begin
                    // Carrier and data together, one cycle after the J is seen
                    st_nxt.crs = 1'b1;
                    st_nxt.rx_dv = 1'b1;
                    st_nxt.rxd = `PREAMBLE_NIB;
                    st_nxt.rx_st = phy_lat_pkg::RX_DATA;
                end else if (nib_edge && !fast && !end_slow(code)) begin
                    // 10M has no delimiter: any symbol other than the idle 00 and end-of-packet 1f opens the frame
                    st_nxt.crs = 1'b1;
                    st_nxt.rx_dv = 1'b1;
                    st_nxt.rxd = code[3:0];
                    st_nxt.rx_st = phy_lat_pkg::RX_DATA;
                end
            end
            phy_lat_pkg::RX_DATA: begin
                if (nib_edge) begin
                    // Error flag stands for one nibble only
                    st_nxt.rx_er = 1'b0;
                    if (fast && end_fast(code)) begin
                        st_nxt.crs = 1'b0;
                        st_nxt.rx_dv = 1'b0;
                        st_nxt.rxd = 4'h0;
                        st_nxt.rx_st = phy_lat_pkg::RX_IDLE;
                    end else if (fast && code == `CODE_K) begin
                        st_nxt.rxd = `PREAMBLE_NIB;
                    end else if (fast) begin
                        // Invalid code groups flag an error but keep the frame
                        st_nxt.rxd = dec[3:0];
                        st_nxt.rx_er = dec[4];
                    end else if (end_slow(code)) begin
                        st_nxt.crs = 1'b0;
                        st_nxt.rx_dv = 1'b0;
                        st_nxt.rxd = 4'h0;
                        st_nxt.rx_st = phy_lat_pkg::RX_IDLE;
                    end else begin
                        st_nxt.rxd = code[3:0];
                    end
                end
            end
            default: begin
                st_nxt.rx_st = phy_lat_pkg::RX_IDLE;
            end
        endcase
        // Synchronous reset wins over every branch above
        if (reset_in) begin
            st_nxt = '0;
            st_nxt.tx_st = phy_lat_pkg::TX_IDLE;
            st_nxt.rx_st = phy_lat_pkg::RX_IDLE;
        end
    end

    // Single state register
    always_ff @(posedge clk_sys_in) begin
        st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign media_tx_pair_out = st_r.line;
    assign media_tx_drive_out = st_r.drive;
    assign mii_crs_out = st_r.crs;
    assign mii_rx_dv_out = st_r.rx_dv;
    assign mii_rx_er_out = st_r.rx_er;
    assign mii_rxd_out = st_r.rxd;
    // Copied receive clock lags the link pin by three or four system cycles
    assign mii_rx_clk_out = st_r.rx_clk;
endmodule

// ### dv/phy_lat_chk.sv
// Latency and framing assertions on the MII path ports
`timescale 1ns/1ps
`include "phy_lat_map.svh"
module phy_lat_chk (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic speed_100_in,
    input wire logic mii_tx_clk_in,
    input wire logic mii_tx_en_in,
    input wire logic [3:0] mii_txd_in,
    input wire logic [4:0] media_rx_pair_in,
    input wire logic [4:0] media_tx_pair_out,
    input wire logic media_tx_drive_out,
    input wire logic mii_crs_out,
    input wire logic mii_rx_dv_out,
    input wire logic mii_rx_er_out,
    input wire logic [3:0] mii_rxd_out,
    input wire logic mii_rx_clk_out
);
    // Windows start at the raw pin edge, so they include the synchroniser delay
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    chk_ssd_late: assert property (speed_100_in && $rose(mii_tx_clk_in) && mii_tx_en_in
        && media_tx_pair_out == `CODE_IDLE |-> ##[2:5] media_tx_pair_out == `CODE_J)
        else $error("start code late");
    chk_esd_late: assert property (speed_100_in && $rose(mii_tx_clk_in) && !mii_tx_en_in
        && !(media_tx_pair_out inside {`CODE_IDLE, `CODE_R, `CODE_T, `CODE_J, 5'h00})
        |-> ##[2:5] media_tx_pair_out == `CODE_T) else $error("end code late");
    chk_crs_on: assert property (speed_100_in && $rose(mii_tx_clk_in) && !mii_crs_out
        && media_rx_pair_in == `CODE_J |-> ##[2:5] mii_crs_out && mii_rx_dv_out
        && mii_rxd_out == 4'h5) else $error("carrier on late");
    chk_crs_off: assert property (speed_100_in && $rose(mii_tx_clk_in) && mii_crs_out
        && media_rx_pair_in == `CODE_T |-> ##[2:5] !mii_crs_out && !mii_rx_dv_out)
        else $error("carrier off late");
    chk_fall_sample: assert property (!speed_100_in && $fell(mii_tx_clk_in) && mii_tx_en_in
        |-> ##[2:5] media_tx_pair_out == {1'b0, $past(mii_txd_in, 2)})
        else $error("slow nibble not taken at falling edge");
    chk_slow_start: assert property (!speed_100_in && $fell(mii_tx_clk_in) && mii_tx_en_in
        && !media_tx_drive_out |-> ##[2:5] media_tx_drive_out) else $error("slow start late");
    chk_eop_hold: assert property (!speed_100_in && $rose(media_tx_pair_out == `LINE10_EOP)
        |-> (media_tx_pair_out == `LINE10_EOP && media_tx_drive_out) [*7] ##1 !media_tx_drive_out)
        else $error("end of packet high time wrong");
    chk_rx_clk: assert property ($rose(mii_tx_clk_in) |-> ##[1:5] $rose(mii_rx_clk_out))
        else $error("receive clock lost");
    chk_er_framed: assert property (!mii_rx_dv_out |-> !mii_rx_er_out)
        else $error("receive error outside frame");
endmodule
bind phy_mii_path_latency phy_lat_chk u_chk (.clk_sys_in, .reset_in, .speed_100_in,
    .mii_tx_clk_in, .mii_tx_en_in, .mii_txd_in, .media_rx_pair_in, .media_tx_pair_out,
    .media_tx_drive_out, .mii_crs_out, .mii_rx_dv_out, .mii_rx_er_out, .mii_rxd_out,
    .mii_rx_clk_out);

// ### dv/mac_model.sv
// MAC-side model driving the MII transmit pins
`timescale 1ns/1ps
module mac_model (
    input wire logic clk_sys_in,
    input wire logic tx_clk_in,
    input wire logic speed_100_in,
    output logic tx_en_out,
    output logic [3:0] txd_out
);
    initial begin
        tx_en_out = 1'b0;
        txd_out = 4'h0;
    end
    // Change away from the sampling edge: falling at 100M, rising at 10M
    task automatic step();
        if (speed_100_in) @(negedge tx_clk_in);
        else @(posedge tx_clk_in);
        @(posedge clk_sys_in);
    endtask
    // One nibble per link clock cycle
    task automatic send(input logic [3:0] q[$]);
        foreach (q[i]) begin
            step();
            tx_en_out <= 1'b1;
            txd_out <= q[i];
        end
        step();
        tx_en_out <= 1'b0;
        // Released data flips so a late sampler sees junk
        txd_out <= ~txd_out;
    endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the MII latency path
`timescale 1ns/1ps
`include "phy_lat_map.svh"
module tb_top;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic speed = 1'b1;
    logic lclk = 1'b0;
    logic tx_en;
    logic [3:0] txd;
    logic [4:0] rxp = `CODE_IDLE;
    logic [4:0] line;
    logic drive;
    logic crs;
    logic dv;
    logic [3:0] rxd;
    logic [4:0] prev_tx, last_tx, prev_rx, last_rx;
    logic mon = 1'b0;
    logic [4:0] txq[$];
    logic [4:0] rxq[$];
    logic [3:0] nq[$];
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h3ef8;
    // Own code table, kept apart from the design's encoder
    localparam logic [4:0] enc_tab[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    always #20 clk_sys_in = ~clk_sys_in;
    // Link clock free running, offset so edges never meet the system clock
    initial begin
        #7;
        forever #160 lclk = ~lclk;
    end

    phy_mii_path_latency DUT (.clk_sys_in, .reset_in, .speed_100_in(speed),
        .mii_tx_clk_in(lclk), .mii_tx_en_in(tx_en), .mii_txd_in(txd),
        .media_rx_pair_in(rxp), .media_tx_pair_out(line), .media_tx_drive_out(drive),
        .mii_crs_out(crs), .mii_rx_dv_out(dv), .mii_rx_er_out(), .mii_rxd_out(rxd),
        .mii_rx_clk_out());
    mac_model mac (.clk_sys_in, .tx_clk_in(lclk), .speed_100_in(speed),
        .tx_en_out(tx_en), .txd_out(txd));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Only changes are visible, so repeated values are noted once
    task automatic note_tx(input logic [4:0] c);
        if (c !== last_tx) txq.push_back(c);
        last_tx = c;
    endtask
    task automatic note_rx(input logic [4:0] c);
        if (c !== last_rx) rxq.push_back(c);
        last_rx = c;
    endtask

    // Each output change takes the oldest note
    always @(posedge clk_sys_in) begin
        if (mon && line !== prev_tx) chk(line, txq.size() ? txq.pop_front() : ~line);
        if (mon && {dv, rxd} !== prev_rx) chk({dv, rxd}, rxq.size() ? rxq.pop_front() : ~{dv, rxd});
        prev_tx <= line;
        prev_rx <= {dv, rxd};
    end

    task automatic tx_frame(input int n);
        nq = {4'h5, 4'h5};
        repeat (n) begin
            seed = xs(seed);
            nq.push_back(seed[3:0]);
        end
        if (speed) begin
            note_tx(`CODE_J);
            note_tx(`CODE_K);
            for (int i = 2; i < nq.size(); i++) note_tx(enc_tab[nq[i]]);
            note_tx(`CODE_T);
            note_tx(`CODE_R);
            note_tx(`CODE_IDLE);
        end else begin
            foreach (nq[i]) note_tx({1'b0, nq[i]});
            note_tx(`LINE10_EOP);
            note_tx(`LINE10_IDLE);
        end
        mac.send(nq);
    endtask

    // Line codes change just after the falling link edge
    task automatic rx_frame(input int n);
        logic [4:0] cq[$];
        cq = {`CODE_J, `CODE_K};
        note_rx(5'h15);
        repeat (n) begin
            seed = xs(seed);
            cq.push_back(enc_tab[seed[7:4]]);
            note_rx({1'b1, seed[7:4]});
        end
        cq.push_back(`CODE_T);
        cq.push_back(`CODE_IDLE);
        note_rx(5'h00);
        foreach (cq[i]) begin
            @(negedge lclk);
            @(posedge clk_sys_in);
            rxp <= cq[i];
        end
    endtask

    task automatic drain();
        for (int i = 0; i < 200 && txq.size() + rxq.size() > 0; i++) @(posedge clk_sys_in);
        repeat (20) @(posedge clk_sys_in);
        chk(5'(txq.size() + rxq.size()), 5'h00);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            $display("BAD %0t timeout", $time);
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (30) @(posedge clk_sys_in);
        chk(line, `CODE_IDLE);
        chk({4'h0, drive}, 5'h01);
        last_tx = `CODE_IDLE;
        last_rx = 5'h00;
        mon <= 1'b1;
        // Shortest frame first, then a longer one, both directions at once
        for (int k = 2; k < 12; k += 7) begin
            fork
                tx_frame(k);
                rx_frame(k + 1);
            join
            drain();
        end
        mon <= 1'b0;
        speed <= 1'b0;
        repeat (30) @(posedge clk_sys_in);
        chk(line, `LINE10_IDLE);
        chk({4'h0, drive}, 5'h00);
        last_tx = `LINE10_IDLE;
        mon <= 1'b1;
        tx_frame(6);
        drain();
        give_verdict();
    end
endmodule
